/* File: plt_host_model.sv */
// register bus host issuing single-cycle strobes
`timescale 1ns/1ps
module plt_host_model (
  input wire logic clock,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata
);
  initial begin
    addr = 8'h0;
    wdata = 16'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // read data is taken in the cycle after the strobe, its only valid slot
  task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask : xfer
endmodule : plt_host_model

/* File: plt_pkg.sv */
// types shared by the pwm level block
package plt_pkg;
  typedef enum logic [2:0] {
    PLT_ST_LOW = 3'b001,
    PLT_ST_HIGH = 3'b010,
    PLT_ST_STATIC = 3'b100
  } plt_pwm_state_t;
  typedef logic [6:0] plt_count_t;
  typedef logic [15:0] plt_word_t;
endpackage : plt_pkg

/* File: plt_pwm_gen.sv */
// pwm generator for the logic-high level of the pin
`timescale 1ns/1ps
`include "plt_regs.svh"
module plt_pwm_gen import plt_pkg::*; (
  input wire logic clock,
  input wire logic nrst,
  plt_pwm_if.gen cfg
);
  plt_pwm_state_t state_ff;
  plt_count_t hc_ff;
  plt_count_t lc_ff;
  plt_count_t left_ff;
  logic tick;
  logic restart_ff;
  logic pwm_ff;
  logic [1:0] tb_ff;

  plt_tick_div u_div (
    .clock(clock),
    .nrst(nrst),
    .sel(tb_ff),
    .restart(restart_ff),
    .tick(tick)
  );

  // static level for degenerate counts
  function automatic logic static_level(input plt_count_t hc, input plt_count_t lc);
    // R4 R5 zero high count is low; R6 zero low count is high
    static_level = (hc != 7'h00) && (lc == 7'h00);
  endfunction : static_level

  assign cfg.pwm_out = pwm_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= PLT_ST_STATIC;
      hc_ff <= 7'h7f;
      lc_ff <= 7'h00;
      left_ff <= 7'h00;
      restart_ff <= 1'b1;
      pwm_ff <= 1'b0;
      tb_ff <= 2'h0;
    end else begin
      restart_ff <= 1'b0;
      case (state_ff)
        PLT_ST_STATIC: begin
          // R13 settings taken every cycle while static, at a period boundary while running
          hc_ff <= cfg.high_count;
          lc_ff <= cfg.low_count;
          tb_ff <= cfg.time_base_sel;
          if (cfg.enable && cfg.high_count != 7'h00 && cfg.low_count != 7'h00) begin
            state_ff <= PLT_ST_HIGH;
            left_ff <= cfg.high_count;
            restart_ff <= 1'b1;
            pwm_ff <= 1'b1;
          end else begin
            pwm_ff <= cfg.enable && static_level(cfg.high_count, cfg.low_count);
          end
        end
        PLT_ST_HIGH: begin
          // R1 high for high count times the time base
          // a tick left over from before the restart would cut the first pulse short
          if (tick && !restart_ff) begin
            if (left_ff == 7'h01) begin
              state_ff <= PLT_ST_LOW;
              left_ff <= lc_ff;
              pwm_ff <= 1'b0;
            end else begin
              left_ff <= left_ff - 7'h01;
            end
          end
        end
        PLT_ST_LOW: begin
          // R2 low for low count times the time base
          if (tick) begin
            if (left_ff == 7'h01) begin
              // R3 period repeats; R13 reload settings
              hc_ff <= cfg.high_count;
              lc_ff <= cfg.low_count;
              tb_ff <= cfg.time_base_sel;
              if (cfg.enable && cfg.high_count != 7'h00 && cfg.low_count != 7'h00) begin
                state_ff <= PLT_ST_HIGH;
                left_ff <= cfg.high_count;
                pwm_ff <= 1'b1;
              end else begin
                state_ff <= PLT_ST_STATIC;
                pwm_ff <= cfg.enable && static_level(cfg.high_count, cfg.low_count);
              end
            end else begin
              left_ff <= left_ff - 7'h01;
            end
          end
        end
        default: begin
          state_ff <= PLT_ST_STATIC;
          pwm_ff <= 1'b0;
        end
      endcase
    end
  end
endmodule : plt_pwm_gen

/* File: plt_pwm_if.sv */
// settings passed from the register file to the pwm generator
`timescale 1ns/1ps
interface plt_pwm_if;
  logic [6:0] high_count;
  logic [6:0] low_count;
  logic [1:0] time_base_sel;
  logic enable;
  logic pwm_out;
  modport regs (output high_count, output low_count, output time_base_sel, output enable, input pwm_out);
  modport gen (input high_count, input low_count, input time_base_sel, input enable, output pwm_out);
endinterface : plt_pwm_if

/* File: plt_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef PLT_REGS_SVH
`define PLT_REGS_SVH
`define PLT_ADDR_W 8
`define PLT_OFF_HL_PWM 8'h58
`define PLT_OFF_SPARE 8'h59
`define PLT_OFF_S1_CRC 8'h7e
`define PLT_OFF_S2_TDAC 8'h80
`define PLT_OFF_CTRL 8'hf0
`define PLT_OFF_STATUS 8'hf1
`define PLT_RST_HL_PWM 16'h3f80
`define PLT_RST_SPARE 16'h5555
`define PLT_RST_S1_CRC 16'h0000
`define PLT_RST_S2_TDAC 16'h0000
`define PLT_RST_CTRL 16'h0000
`define PLT_HC_MSB 13
`define PLT_HC_LSB 7
`define PLT_LC_MSB 6
`define PLT_LC_LSB 0
`define PLT_S2_EN_BIT 15
`define PLT_TDAC_MSB 2
`define PLT_TB_MSB 1
`define PLT_TB_LSB 0
`define PLT_TB_CYC0 16
`define PLT_TB_CYC1 64
`define PLT_TB_CYC2 1024
`define PLT_TB_CNT_W 10
`endif

/* File: plt_regs_top.sv */
// register slice with the pin pwm level generator
//
// Summary of operation
// R1: in pwm mode the pin is high for the high count times the time base.
// R2: in pwm mode the pin is low for the low count times the time base.
// R3: a period is the sum of both counts times the time base and repeats.
// R4: a zero high count gives a constant low level.
// R5: both counts zero gives a constant low level.
// R6: only the low count zero gives a constant high level.
// R7: the pwm count register resets to high count all ones, low count zero, top bits zero.
// R8: a 16-bit spare word resets to 5555h, does nothing, and feeds the section-1 crc; here it only reads back and is not passed out of the slice.
// R9: a 16-bit word holds the stored section-1 crc and resets to zero.
// R10: bit 15 of the section-2 word enables the section-2 crc, reset disabled.
// R11: a 3-bit field selects the test dac a output level.
// R12: a 2-bit field selects a time base of 16, 64 or 1024 clock periods.
// R13: new counts take effect at the next period boundary.
// R14: an enabled section crc is compared against its stored value and mismatch flagged.
`timescale 1ns/1ps
`include "plt_regs.svh"
module plt_regs_top import plt_pkg::*; (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] s1_crc_calc,
  input wire logic [15:0] s2_crc_calc,
  input wire logic [15:0] s2_crc_stored,
  output logic [15:0] rdata,
  output logic high_level_pwm_out,
  output logic [2:0] test_dac_a_level_sel,
  output logic section2_crc_enable,
  output logic crc_error
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  plt_word_t hl_pwm_ff;
  plt_word_t spare_ff;
  plt_word_t s1_crc_ff;
  plt_word_t s2_tdac_ff;
  plt_word_t ctrl_ff;
  logic s1_err_ff;
  logic s2_err_ff;
  logic pwm_q;

  plt_pwm_if pwm_cfg ();

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // R7 pwm counts; reserved bits 15:14 never stored
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hl_pwm_ff <= `PLT_RST_HL_PWM;
    end else if (wr && hit(addr, `PLT_OFF_HL_PWM)) begin
      hl_pwm_ff <= {2'h0, wdata[`PLT_HC_MSB:`PLT_LC_LSB]};
    end
  end

  // R8 spare word
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      spare_ff <= `PLT_RST_SPARE;
    end else if (wr && hit(addr, `PLT_OFF_SPARE)) begin
      spare_ff <= wdata;
    end
  end

  // R9 stored section-1 crc
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_crc_ff <= `PLT_RST_S1_CRC;
    end else if (wr && hit(addr, `PLT_OFF_S1_CRC)) begin
      s1_crc_ff <= wdata;
    end
  end

  // R10 R11 crc enable and test dac select, reserved bits zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s2_tdac_ff <= `PLT_RST_S2_TDAC;
    end else if (wr && hit(addr, `PLT_OFF_S2_TDAC)) begin
      s2_tdac_ff <= {wdata[`PLT_S2_EN_BIT], 12'h000, wdata[`PLT_TDAC_MSB:0]};
    end
  end

  // control: bit 15 pwm enable, bit 14 section-1 crc enable, bits 1:0 time base
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= `PLT_RST_CTRL;
    end else if (wr && hit(addr, `PLT_OFF_CTRL)) begin
      ctrl_ff <= {wdata[15:14], 12'h000, wdata[`PLT_TB_MSB:`PLT_TB_LSB]};
    end
  end

  // ------------------------------------------------------------
  // pwm generator
  // ------------------------------------------------------------
  assign pwm_cfg.high_count = hl_pwm_ff[`PLT_HC_MSB:`PLT_HC_LSB];
  assign pwm_cfg.low_count = hl_pwm_ff[`PLT_LC_MSB:`PLT_LC_LSB];
  // R12 time base select
  assign pwm_cfg.time_base_sel = ctrl_ff[`PLT_TB_MSB:`PLT_TB_LSB];
  assign pwm_cfg.enable = ctrl_ff[15];
  assign pwm_q = pwm_cfg.pwm_out;

  plt_pwm_gen u_gen (
    .clock(clock),
    .nrst(nrst),
    .cfg(pwm_cfg)
  );

  // ------------------------------------------------------------
  // crc compare
  // ------------------------------------------------------------
  // R14 sticky mismatch flags; a new mismatch beats a status write clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_err_ff <= 1'b0;
      s2_err_ff <= 1'b0;
    end else begin
      if (ctrl_ff[14] && s1_crc_calc != s1_crc_ff) begin
        s1_err_ff <= 1'b1;
      end else if (wr && hit(addr, `PLT_OFF_STATUS) && wdata[0]) begin
        s1_err_ff <= 1'b0;
      end
      if (s2_tdac_ff[`PLT_S2_EN_BIT] && s2_crc_calc != s2_crc_stored) begin
        s2_err_ff <= 1'b1;
      end else if (wr && hit(addr, `PLT_OFF_STATUS) && wdata[1]) begin
        s2_err_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // outputs and read port
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      high_level_pwm_out <= 1'b0;
      test_dac_a_level_sel <= 3'h0;
      section2_crc_enable <= 1'b0;
      crc_error <= 1'b0;
    end else begin
      high_level_pwm_out <= pwm_q;
      test_dac_a_level_sel <= s2_tdac_ff[`PLT_TDAC_MSB:0];
      section2_crc_enable <= s2_tdac_ff[`PLT_S2_EN_BIT];
      crc_error <= s1_err_ff || s2_err_ff;
    end
  end

  // unmapped addresses read zero; rdata holds zero outside the answer cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `PLT_OFF_HL_PWM: rdata <= hl_pwm_ff;
        `PLT_OFF_SPARE: rdata <= spare_ff;
        `PLT_OFF_S1_CRC: rdata <= s1_crc_ff;
        `PLT_OFF_S2_TDAC: rdata <= s2_tdac_ff;
        `PLT_OFF_CTRL: rdata <= ctrl_ff;
        `PLT_OFF_STATUS: rdata <= {13'h0000, pwm_q, s2_err_ff, s1_err_ff};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule : plt_regs_top

/* File: plt_regs_top_monitor.sv */
// port-level assertions for the register slice
`timescale 1ns/1ps
module plt_regs_top_monitor (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic high_level_pwm_out,
  input wire logic [2:0] test_dac_a_level_sel,
  input wire logic section2_crc_enable
);
  // ----
  // read-back, reserved bits, outputs, pwm phases and idle read data
  // ----
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence s_wr_rd;
    wr && (addr == 8'h59 || addr == 8'h7e) ##1 rd && addr == $past(addr);
  endsequence
  sequence s_wr_hl;
    wr && addr == 8'h58 ##1 rd && addr == 8'h58;
  endsequence
  sequence s_wr_s2;
    wr && addr == 8'h80;
  endsequence
  AST_HL_RSVD: assert property (rd && addr == 8'h58 |=> rdata[15:14] == 2'h0)
    else $error("pwm count word top bits set");
  AST_HL_BACK: assert property (s_wr_hl |=> rdata == ($past(wdata, 2) & 16'h3fff))
    else $error("pwm count word read back wrong");
  AST_S2_RSVD: assert property (rd && addr == 8'h80 |=> rdata[14:3] == 12'h0)
    else $error("section2 word reserved bits set");
  AST_RW_BACK: assert property (s_wr_rd |=> rdata == $past(wdata, 2))
    else $error("word read back wrong");
  AST_S2_OUT: assert property (s_wr_s2 |-> ##2
    {section2_crc_enable, 12'h0, test_dac_a_level_sel} == ($past(wdata, 2) & 16'h8007))
    else $error("enable or dac select output stale");
  AST_HIGH_MIN: assert property ($rose(high_level_pwm_out) |=> high_level_pwm_out [*7])
    else $error("pwm high phase too short");
  AST_LOW_MIN: assert property ($fell(high_level_pwm_out) |=> !high_level_pwm_out [*7])
    else $error("pwm low phase too short");
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 16'h0)
    else $error("read data outside read slot");
endmodule : plt_regs_top_monitor
bind plt_regs_top plt_regs_top_monitor mon (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .high_level_pwm_out(high_level_pwm_out),
  .test_dac_a_level_sel(test_dac_a_level_sel), .section2_crc_enable(section2_crc_enable));

/* File: plt_regs_top_test.sv */
// self-checking bench for the register slice
`timescale 1ns/1ps
module plt_regs_top_test import plt_pkg::*; ;
  typedef struct {logic [7:0] a; plt_word_t w; plt_word_t r0; plt_word_t r1;} plt_row_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  plt_word_t s1_calc = 16'h1234;
  plt_word_t s2_calc = 16'h0;
  plt_word_t s2_stored = 16'h0;
  logic [7:0] addr;
  plt_word_t wdata;
  logic wr;
  logic rd;
  plt_word_t rdata;
  logic pwm_out;
  logic [2:0] dac_sel;
  logic crc_en;
  logic crc_err;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  int hi;
  int lo;
  plt_word_t q;
  plt_row_t rows [6] = '{'{8'h58, 16'hc103, 16'h3f80, 16'h0103}, '{8'h59, 16'ha5a5, 16'h5555, 16'ha5a5},
    '{8'h7e, 16'h1234, 16'h0000, 16'h1234}, '{8'h80, 16'hffff, 16'h0000, 16'h8007},
    '{8'h42, 16'hffff, 16'h0000, 16'h0000}, '{8'hf0, 16'h3ffb, 16'h0000, 16'h0003}};
  plt_word_t st_cfg [4] = '{16'h0180, 16'h0000, 16'h0180, 16'h0005};
  logic st_lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  always #2 clock = ~clock;
  plt_host_model host (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  plt_regs_top dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .s1_crc_calc(s1_calc), .s2_crc_calc(s2_calc), .s2_crc_stored(s2_stored), .rdata(rdata),
    .high_level_pwm_out(pwm_out), .test_dac_a_level_sel(dac_sel), .section2_crc_enable(crc_en),
    .crc_error(crc_err));
  task automatic chk(input plt_word_t seen, input plt_word_t exp, input string name);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // sampling 1 ns after the edge keeps reads clear of that edge's updates
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_cyc
  // skips to a rising edge, then counts one high and one low phase
  task automatic pwm_len(output int h, output int l);
    h = 0;
    l = 0;
    for (int k = 0; k < 5000 && pwm_out !== 1'b0; k++) wait_cyc(1);
    for (int k = 0; k < 5000 && pwm_out !== 1'b1; k++) wait_cyc(1);
    for (; h < 5000 && pwm_out === 1'b1; h++) wait_cyc(1);
    for (; l < 5000 && pwm_out === 1'b0; l++) wait_cyc(1);
  endtask : pwm_len
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    chk({13'h0000, pwm_out, crc_en, crc_err}, 16'h0, "outputs in reset");
    nrst <= 1'b1;
    wait_cyc(1);
    foreach (rows[i]) begin
      host.xfer(1'b0, 1'b1, rows[i].a, 16'h0, q);
      chk(q, rows[i].r0, "reset value");
      host.xfer(1'b1, 1'b0, rows[i].a, rows[i].w, q);
      host.xfer(1'b0, 1'b1, rows[i].a, 16'h0, q);
      chk(q, rows[i].r1, "read back");
    end
    for (int c = 0; c < 8; c++) begin
      host.xfer(1'b1, 1'b0, 8'h80, {c[0], 12'h0, c[2:0]}, q);
      wait_cyc(3);
      chk({12'h0, crc_en, dac_sel}, {12'h0, c[0], c[2:0]}, "dac select");
    end
    host.xfer(1'b1, 1'b0, 8'hf0, 16'h8000, q);
    pwm_len(hi, lo);
    pwm_len(hi, lo);
    chk(16'(hi), 16'h20, "high cycles");
    chk(16'(lo), 16'h30, "low cycles");
    host.xfer(1'b1, 1'b0, 8'h58, 16'h0081, q);
    host.xfer(1'b1, 1'b0, 8'hf0, 16'h8001, q);
    pwm_len(hi, lo);
    pwm_len(hi, lo);
    chk(16'(hi + lo), 16'h80, "period cycles");
    for (int t = 2; t < 4; t++) begin
      host.xfer(1'b1, 1'b0, 8'hf0, {1'b1, 13'h0000, t[1:0]}, q);
      pwm_len(hi, lo);
      pwm_len(hi, lo);
      chk(16'(hi + lo), 16'h0800, "long period cycles");
    end
    host.xfer(1'b1, 1'b0, 8'hf0, 16'h8000, q);
    pwm_len(hi, lo);
    chk(16'(hi + lo), 16'h0020, "period after time base change");
    foreach (st_cfg[i]) begin
      host.xfer(1'b1, 1'b0, 8'h58, st_cfg[i], q);
      wait_cyc(300);
      chk({15'h0, pwm_out}, {15'h0, st_lvl[i]}, "static level");
    end
    host.xfer(1'b1, 1'b0, 8'hf0, 16'h4000, q);
    wait_cyc(4);
    chk({15'h0, crc_err}, 16'h0, "crc match");
    s1_calc <= 16'h1235;
    wait_cyc(4);
    chk({15'h0, crc_err}, 16'h1, "crc mismatch");
    s1_calc <= 16'h1234;
    host.xfer(1'b1, 1'b0, 8'hf1, 16'h0001, q);
    wait_cyc(4);
    chk({15'h0, crc_err}, 16'h0, "crc cleared");
    s2_calc <= 16'h0001;
    wait_cyc(4);
    chk({15'h0, crc_err}, 16'h1, "section2 mismatch");
    nrst <= 1'b0;
    wait_cyc(2);
    chk({14'h0, crc_en, crc_err}, 16'h0, "outputs in reset");
    nrst <= 1'b1;
    wait_cyc(1);
    host.xfer(1'b0, 1'b1, 8'h59, 16'h0, q);
    chk(q, 16'h5555, "spare after reset");
    conclude();
  end
endmodule : plt_regs_top_test

/* File: plt_tick_div.sv */
// time-base divider producing a one-cycle tick enable
`timescale 1ns/1ps
`include "plt_regs.svh"
module plt_tick_div import plt_pkg::*; #(
  parameter int unsigned CNT_W = `PLT_TB_CNT_W
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] sel,
  input wire logic restart,
  output logic tick
);
  // the longest time base needs ten counter bits
  if (CNT_W < 10) begin : g_cnt_w_check
    $error("plt_tick_div: counter too narrow for 1024");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] last;

  always_comb begin
    case (sel)
      2'h0: last = CNT_W'(`PLT_TB_CYC0 - 1);
      2'h1: last = CNT_W'(`PLT_TB_CYC1 - 1);
      default: last = CNT_W'(`PLT_TB_CYC2 - 1);
    endcase
  end

  // R12 time base count
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else if (restart) begin
      // starting at two lines the first tick up with the pwm edge that the restart arrives with in the same cycle
      cnt_ff <= CNT_W'(2);
    end else if (cnt_ff >= last) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick <= 1'b0;
    end else begin
      tick <= !restart && (cnt_ff >= last);
    end
  end
endmodule : plt_tick_div
